// >>> include/sbc_mode_pkg.sv
// constants for the mode register global command decoder
package sbc_mode_pkg;
  localparam int          FRAME_BITS          = 16;
  localparam int          COUNT_BITS          = 5;
  localparam logic [4:0]  MODE_REG_ADDR       = 5'h0E;
  localparam logic [1:0]  GLOBAL_PLAIN_PREFIX = 2'h0;
  localparam logic [1:0]  GLOBAL_DEBUG_PREFIX = 2'h3;
  localparam logic [1:0]  WRITE_PREFIX        = 2'h1;
  localparam int          PREFIX_HI           = 15;
  localparam int          PREFIX_LO           = 14;
  localparam int          ADDR_HI             = 13;
  localparam int          ADDR_LO             = 9;
  localparam int          GLOBAL_MARK_BIT     = 8;
  localparam int          SAFE_OFF_BIT        = 7;
  localparam int          MODE_HI             = 7;
  localparam int          MODE_LO             = 3;
  localparam int          CODE_HI             = 2;
  localparam int          STATUS_HI           = 15;
  localparam int          STATUS_LO           = 8;
  localparam logic [6:0]  GLOBAL_TAIL         = 7'h00;
  localparam logic [4:0]  MODE_STARTUP        = 5'h00;
  localparam logic [4:0]  MODE_PROGRAMMING    = 5'h01;
  localparam logic [4:0]  MODE_NORMAL_REQUEST = 5'h02;
  localparam logic [4:0]  MODE_NORMAL         = 5'h03;
  localparam int          LOW_POWER_BIT       = 4;
  localparam logic [1:0]  SUPPLY_OFF_TAG      = 2'h1;
  localparam int          FORCED_WAKEUP_BIT   = 1;
  localparam int          CYCLIC_SENSE_BIT    = 0;
  localparam int          CYCLIC_SENSE_ON_BIT = 2;
  localparam int          FORCED_WAKEUP_ON_BIT = 3;
  localparam logic [2:0]  RANDOM_SEED         = 3'h5;
  localparam logic [2:0]  CODE_NONE           = 3'h0;
  localparam logic [15:0] REPLY_RESET         = 16'h0000;
endpackage : sbc_mode_pkg

// >>> include/random_code_if.sv
// carries the 3-bit random code from its generator to the decoder
`timescale 1ns/1ps
`default_nettype none
interface random_code_if;
  logic [2:0] code;
  modport producer (output code);
  modport consumer (input code);
endinterface : random_code_if
`default_nettype wire

// >>> core/random_code_gen.sv
// free-running 3-bit code generator feeding the random-code reads
`timescale 1ns/1ps
`default_nettype none
module random_code_gen
  import sbc_mode_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  random_code_if.producer out
);
  // steps every clock, so the value seen by a read depends on host timing
  always_ff @(posedge clock) begin
    if (srst) begin
      out.code <= RANDOM_SEED;
    end else begin
      out.code <= {out.code[1:0], out.code[2] ^ out.code[1]};
    end
  end
endmodule : random_code_gen
`default_nettype wire

// >>> core/sbc_mode_global_commands.sv
// spi decoder for the mode register and its global commands
// Operation
// - mode address in bits 13-9; bits 15-14, bit 8 and bit 7 pick the function
// - protected entry is selected only while in startup mode
// - in normal mode host reads random code with 0x1D00 or 0x1D80
// - random code is returned on reply bits 2, 1 and 0
// - protected low-power write carries inverted last random code in bits 2-0
// - unprotected 0x5C60 enters supply-off low power, no forced wakeup or sensing
// - 1D00 reports mode, leaves debug, safe output unchanged, returns code
// - 1D80 reports mode, switches safe output off, returns code
// - DD00 reports mode, leaves debug, bits 1 and 0 give safe and debug
// - DD80 reports mode, keeps debug, switches safe off, returns safe/debug
// - mode code in bits 7-3; leading one marks low power
// - bit 1 is safe driver on, bit 0 is debug active
// - write 0x5C10 wakes device from supply-on or supply-off low power
// - inverted random bits are optional, enabled beforehand in startup
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_global_commands
  import sbc_mode_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  input  wire logic [7:0] fixed_status,
  input  wire logic       protected_entry_select,
  input  wire logic       debug_strap,
  output logic            spi_miso,
  output logic [4:0]      current_mode,
  output logic            safe_output_on,
  output logic            debug_active,
  output logic            low_power_supply_off,
  output logic            forced_wakeup,
  output logic            cyclic_sense
);
  import sbc_mode_pkg::*;

  random_code_if code_bus ();

  random_code_gen code_gen (
    .clock (clock),
    .srst  (srst),
    .out   (code_bus.producer)
  );

  logic                  sclk_prev;
  logic                  cs_n_prev;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [COUNT_BITS-1:0] bit_count;
  logic [FRAME_BITS-1:0] reply;
  logic [2:0]            last_code;
  logic                  protected_entry;
  logic                  strap_taken;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       frame_start;
  logic       frame_done;
  logic [1:0] prefix;
  logic       addr_hit;
  logic       is_global;
  logic       is_read_plain;
  logic       is_read_debug;
  logic       is_write;
  logic       safe_off_req;
  logic [4:0] wr_mode;
  logic       wr_low_power;
  logic       wr_supply_off;
  logic       code_ok;

  assign sclk_rise   = spi_sclk && !sclk_prev && !spi_cs_n;
  assign sclk_fall   = !spi_sclk && sclk_prev && !spi_cs_n;
  assign frame_start = !spi_cs_n && cs_n_prev;
  // a frame counts only when the 5-bit count reads sixteen at close (16 or 48 clocks, as it wraps); others are dropped
  assign frame_done  = spi_cs_n && !cs_n_prev && (bit_count == COUNT_BITS'(FRAME_BITS));

  assign prefix        = shift_in[PREFIX_HI:PREFIX_LO];
  assign addr_hit      = shift_in[ADDR_HI:ADDR_LO] == MODE_REG_ADDR;
  assign is_global     = addr_hit && shift_in[GLOBAL_MARK_BIT]
                         && (shift_in[SAFE_OFF_BIT-1:0] == GLOBAL_TAIL);
  assign is_read_plain = is_global && (prefix == GLOBAL_PLAIN_PREFIX);
  assign is_read_debug = is_global && (prefix == GLOBAL_DEBUG_PREFIX);
  assign safe_off_req  = shift_in[SAFE_OFF_BIT];
  assign is_write      = addr_hit && (prefix == WRITE_PREFIX);
  assign wr_mode       = shift_in[MODE_HI:MODE_LO];
  // supply-off selections are written as 0 11xx, supply-on as 1 xxxx
  assign wr_supply_off = wr_mode[MODE_HI-MODE_LO -: 2] == SUPPLY_OFF_TAG
                         && wr_mode[CYCLIC_SENSE_ON_BIT]
                         && wr_mode[FORCED_WAKEUP_ON_BIT];
  assign wr_low_power  = wr_mode[LOW_POWER_BIT] || wr_supply_off;
  // held code, not the live one: the generator keeps stepping after the read
  assign code_ok       = !protected_entry
                         || (shift_in[CODE_HI:0] == ~last_code);

  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_prev <= 1'b0;
      cs_n_prev <= 1'b1;
    end else begin
      sclk_prev <= spi_sclk;
      cs_n_prev <= spi_cs_n;
    end
  end

  // mode 0 framing: sample on rising sclk, msb first
  always_ff @(posedge clock) begin
    if (srst) begin
      shift_in  <= '0;
      bit_count <= '0;
    end else if (frame_start) begin
      bit_count <= '0;
    end else if (sclk_rise) begin
      shift_in  <= {shift_in[FRAME_BITS-2:0], spi_mosi};
      bit_count <= bit_count + COUNT_BITS'(1);
    end
  end

  // reply of one frame is shifted out during the next frame
  always_ff @(posedge clock) begin
    if (srst) begin
      shift_out <= REPLY_RESET;
      spi_miso  <= 1'b0;
    end else if (frame_start) begin
      shift_out <= {reply[FRAME_BITS-2:0], 1'b0};
      spi_miso  <= reply[FRAME_BITS-1];
    end else if (sclk_fall) begin
      shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
      spi_miso  <= shift_out[FRAME_BITS-1];
    end
  end

  // reply samples the state held before this frame's own effects land
  always_ff @(posedge clock) begin
    if (srst) begin
      reply     <= REPLY_RESET;
      last_code <= CODE_NONE;
    end else if (frame_done) begin
      if (is_read_plain) begin
        reply     <= {fixed_status, current_mode, code_bus.code};
        if (current_mode == MODE_NORMAL) begin
          last_code <= code_bus.code;
        end
      end else if (is_read_debug) begin
        reply <= {fixed_status, current_mode, 1'b0,
                  safe_output_on, debug_active};
      end else begin
        reply <= {fixed_status, current_mode, CODE_NONE};
      end
    end
  end

  // option is only latched while still in startup mode
  always_ff @(posedge clock) begin
    if (srst) begin
      protected_entry <= 1'b0;
    end else if (current_mode == MODE_STARTUP) begin
      protected_entry <= protected_entry_select;
    end
  end

  // debug strap is caught on the first clock after reset release
  always_ff @(posedge clock) begin
    if (srst) begin
      strap_taken  <= 1'b0;
      debug_active <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      debug_active <= debug_strap;
    end else if (frame_done && is_global && !safe_off_req) begin
      debug_active <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      safe_output_on <= 1'b1;
    end else if (frame_done && is_global && safe_off_req) begin
      safe_output_on <= 1'b0;
    end
  end

  // wake-up flags are cleared by the wake request, so a stale flag cannot wake the device again outside
  always_ff @(posedge clock) begin
    if (srst) begin
      current_mode         <= MODE_STARTUP;
      low_power_supply_off <= 1'b0;
      forced_wakeup        <= 1'b0;
      cyclic_sense         <= 1'b0;
    end else if (frame_done && is_write) begin
      if (wr_low_power) begin
        if (code_ok && current_mode == MODE_NORMAL) begin
          current_mode         <= {1'b1, wr_mode[LOW_POWER_BIT-1:0]};
          low_power_supply_off <= wr_supply_off;
          forced_wakeup        <= wr_supply_off ? wr_mode[FORCED_WAKEUP_BIT]
                                                : wr_mode[FORCED_WAKEUP_ON_BIT];
          cyclic_sense         <= wr_supply_off ? wr_mode[CYCLIC_SENSE_BIT]
                                                : wr_mode[CYCLIC_SENSE_ON_BIT];
        end
      end else if (wr_mode == MODE_NORMAL_REQUEST) begin
        current_mode         <= MODE_NORMAL_REQUEST;
        low_power_supply_off <= 1'b0;
        forced_wakeup        <= 1'b0;
        cyclic_sense         <= 1'b0;
      // only a wake request leaves low power; other mode writes are refused there
      end else if (wr_mode == MODE_NORMAL || wr_mode == MODE_PROGRAMMING) begin
        if (!current_mode[LOW_POWER_BIT]) begin
          current_mode <= wr_mode;
        end
      end
    end
  end
endmodule : sbc_mode_global_commands
`default_nettype wire

// >>> verification/sbc_mode_checker.sv
// port assertions for the mode register global command decoder
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_checker (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       spi_sclk,
  input wire logic       spi_cs_n,
  input wire logic       spi_mosi,
  input wire logic       protected_entry_select,
  input wire logic [4:0] current_mode,
  input wire logic       safe_output_on,
  input wire logic       debug_active,
  input wire logic       low_power_supply_off,
  input wire logic       forced_wakeup,
  input wire logic       cyclic_sense
);
  logic        sclk_q;
  logic        cs_q;
  logic        prot;
  logic [4:0]  cnt;
  logic [15:0] word;
  logic        fin;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // a frame counts only when cs_n closes with the 5-bit count at sixteen (16 or 48 clock rises, as it wraps)
  assign fin = spi_cs_n && !cs_q && (cnt == 5'h10);
  always_ff @(posedge clock) begin
    sclk_q <= spi_sclk;
    cs_q   <= spi_cs_n;
  end
  always_ff @(posedge clock) begin
    if (srst || spi_cs_n) cnt <= 5'h00;
    else if (spi_sclk && !sclk_q) cnt <= cnt + 5'h01;
  end
  always_ff @(posedge clock) begin
    if (!spi_cs_n && spi_sclk && !sclk_q) word <= {word[14:0], spi_mosi};
  end
  always_ff @(posedge clock) begin
    if (current_mode == 5'h00) prot <= protected_entry_select;
  end
  property p_foreign; fin && word[13:9] != 5'h0E |=> $stable(current_mode) [*3]; endproperty
  a_foreign: assert property (p_foreign) else $error("mode moved on a foreign frame");
  property p_mark; fin && word == 16'h1C80 |=> $stable(safe_output_on) [*3]; endproperty
  a_mark: assert property (p_mark) else $error("frame without bit 8 acted on");
  property p_safe_off; fin && word == 16'h1D80 |-> ##[1:3] !safe_output_on; endproperty
  a_safe_off: assert property (p_safe_off) else $error("safe output left on");
  property p_keep_debug;
    fin && word == 16'hDD80 && debug_active |-> ##[1:3] (!safe_output_on && debug_active);
  endproperty
  a_keep_debug: assert property (p_keep_debug) else $error("debug kept, safe off failed");
  property p_leave; fin && (word == 16'h1D00 || word == 16'hDD00) |-> ##[1:3] !debug_active;
  endproperty
  a_leave: assert property (p_leave) else $error("debug not left");
  property p_safe_kept; fin && word == 16'h1D00 |=> $stable(safe_output_on) [*3]; endproperty
  a_safe_kept: assert property (p_safe_kept) else $error("safe output changed");
  property p_sleep;
    fin && word == 16'h5C60 && current_mode == 5'h03 && !prot |-> ##[1:3]
      (current_mode == 5'h1C && low_power_supply_off && !forced_wakeup && !cyclic_sense);
  endproperty
  a_sleep: assert property (p_sleep) else $error("supply-off entry wrong");
  property p_wake; fin && word == 16'h5C10 && current_mode[4] |-> ##[1:3] current_mode == 5'h02;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request write");
endmodule : sbc_mode_checker
bind sbc_mode_global_commands sbc_mode_checker i_sbc_mode_checker (.clock, .srst, .spi_sclk,
  .spi_cs_n, .spi_mosi, .protected_entry_select, .current_mode, .safe_output_on, .debug_active,
  .low_power_supply_off, .forced_wakeup, .cyclic_sense);
`default_nettype wire

// >>> verification/spi_host_model.sv
// spi host standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic clock,
  output logic      spi_sclk = 1'b0,
  output logic      spi_cs_n = 1'b1,
  output logic      spi_mosi = 1'b0,
  input  wire logic spi_miso
);
  // mode 0, msb first, two clocks per half period; reply read mid high phase
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clock) spi_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clock) spi_mosi <= w[15 - i];
      @(posedge clock) spi_sclk <= 1'b1;
      @(posedge clock) r[15 - i] = spi_miso;
      @(posedge clock) spi_sclk <= 1'b0;
    end
    @(posedge clock) spi_cs_n <= 1'b1;
    // line has no pull, so a released line must not keep the last bit
    spi_mosi <= ~spi_mosi;
    repeat (3) @(posedge clock);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the mode register global command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbc_mode_pkg::*;
  logic        clock, srst, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  logic        protected_entry_select, debug_strap, safe_output_on, debug_active;
  logic        low_power_supply_off, forced_wakeup, cyclic_sense;
  logic [7:0]  fixed_status;
  logic [4:0]  current_mode;
  logic [15:0] rep, w;
  logic [2:0]  code;
  int          failures = 0;
  int          tests_run = 0;
  sbc_mode_global_commands i_sbc_mode_global_commands (.clock, .srst, .spi_sclk, .spi_cs_n,
    .spi_mosi, .fixed_status, .protected_entry_select, .debug_strap, .spi_miso, .current_mode,
    .safe_output_on, .debug_active, .low_power_supply_off, .forced_wakeup, .cyclic_sense);
  spi_host_model i_spi_host_model (.clock, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [15:0] reply(logic [4:0] m, logic s, logic d);
    return {fixed_status, m, 1'b0, s, d};
  endfunction : reply
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic send(input logic [15:0] x);
    i_spi_host_model.xfer(x, 16, rep);
    repeat (2) @(posedge clock);
  endtask : send
  task automatic do_reset(input logic p);
    srst <= 1'b1;
    protected_entry_select <= p;
    fixed_status <= 8'($urandom);
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : do_reset
  task automatic final_report();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    fixed_status = 8'h00;
    protected_entry_select = 1'b0;
    debug_strap = 1'b1;
    void'($urandom(32'h8C6D9CC5));
    do_reset(1'b0);
    chk({current_mode, safe_output_on, debug_active}, {MODE_STARTUP, 2'h3});
    send(16'h5C18);
    chk(current_mode, MODE_NORMAL);
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      if (w[13:9] == MODE_REG_ADDR) w[13:9] = 5'h0F;
      send(w);
      chk({current_mode, safe_output_on}, {MODE_NORMAL, 1'b1});
    end
    send(16'h1C80);
    chk(rep, reply(MODE_NORMAL, 1'b0, 1'b0));
    chk(safe_output_on, 1'b1);
    send(16'hDD80);
    chk({safe_output_on, debug_active}, 2'h1);
    send(16'h1D00);
    // the reply is the DD80 read, showing safe and debug as they stood before DD80 acted
    chk(rep, reply(MODE_NORMAL, 1'b1, 1'b1));
    chk({safe_output_on, debug_active}, 2'h0);
    send(16'hDD00);
    chk(rep[15:3], {fixed_status, MODE_NORMAL});
    send(16'h1D80);
    chk(rep, reply(MODE_NORMAL, 1'b0, 1'b0));
    send(16'hE100);
    chk(rep[15:3], {fixed_status, MODE_NORMAL});
    send(16'h5C60);
    chk(rep, reply(MODE_NORMAL, 1'b0, 1'b0));
    chk({current_mode, low_power_supply_off, forced_wakeup, cyclic_sense}, 8'hE4);
    send(16'h5C10);
    chk(current_mode, MODE_NORMAL_REQUEST);
    send(16'h5C18);
    chk(current_mode, MODE_NORMAL);
    send(16'h5CC0);
    chk({current_mode, low_power_supply_off, forced_wakeup, cyclic_sense}, 8'hC2);
    send(16'h5C10);
    chk(current_mode, MODE_NORMAL_REQUEST);
    debug_strap <= 1'b0;
    do_reset(1'b1);
    chk({current_mode, safe_output_on, debug_active}, {MODE_STARTUP, 2'h2});
    i_spi_host_model.xfer(16'h1D80, 15, rep);
    repeat (2) @(posedge clock);
    chk(safe_output_on, 1'b1);
    send(16'h5C18);
    protected_entry_select <= 1'b0;
    send(16'h1D00);
    chk(safe_output_on, 1'b1);
    send(16'h1D80);
    chk(safe_output_on, 1'b0);
    send(16'hDD00);
    code = rep[2:0];
    send({13'h0B8C, code});
    chk(current_mode, MODE_NORMAL);
    send({13'h0B8C, ~code});
    chk({current_mode, low_power_supply_off}, 6'h39);
    final_report();
  end
endmodule : tb
`default_nettype wire
